// ### hdl/frw_pkg.sv
/*
 * Package for the flash row write latch programmer: register offsets,
 * field positions, reset values, unlock keys, region limits and types.
 * Assumes a 32-bit APB slave with one register per aligned word.
 */
package frw_pkg;
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_UNLOCK   = 8'h04;
	localparam logic [7:0]  ADDR_NVADDR   = 8'h08;
	localparam logic [7:0]  ADDR_NVDATA   = 8'h0C;
	localparam logic [7:0]  ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_MASK = 8'h14;
	localparam int          CTRL_START    = 0;
	localparam int          CTRL_WRITE_ENABLE_BIT     = 1;
	localparam int          CTRL_LATCH_LOAD_ONLY     = 2;
	localparam int          CTRL_REGION   = 3;
	localparam int          CTRL_WRITE_ERROR_FLAG    = 4;
	localparam int          CTRL_BUSY     = 5;
	localparam int          IRQ_DONE      = 0;
	localparam int          IRQ_ERR       = 1;
	localparam logic [7:0]  KEY_FIRST     = 8'h55;
	localparam logic [7:0]  KEY_SECOND    = 8'hAA;
	localparam logic [13:0] LATCH_BLANK   = 14'h3FFF;
	localparam logic [15:0] PFM_FIRST     = 16'h8000;
	localparam logic [15:0] PFM_LAST      = 16'h87FF;
	localparam logic [15:0] UID_LAST      = 16'h8003;
	localparam logic [15:0] EE_FIRST      = 16'hF000;
	localparam logic [15:0] EE_LAST       = 16'hF0FF;
	localparam int          ROW_WORDS     = 32;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_GOT55,
		KEY_ARMED
	} frw_key_type;

	typedef struct packed {
		logic        we;
		logic [9:0]  row;
		logic        region;
		logic [4:0]  index;
		logic [13:0] data;
	} frw_flash_type;
endpackage

// ### hdl/frw_programmer.sv
/*
 * Flash row write latch programmer: APB registers, unlock sequencer,
 * 32 write latches and the row commit engine toward the flash array.
 * Assumes an APB master on clk_sys and a flash array that accepts one
 * word per cycle on the flash port and raises flash_ready when idle.
 */
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps

//
// Contract
// R1 - Software programs only erased or unwritten words; no erase is done.
// R2 - There are 32 write latches and a commit writes at most 32 words.
// R3 - The row comes from address bits 14:5 and bits 4:0 pick the latch.
// R4 - A commit writes only the addressed row and never its neighbours.
// R5 - Every latch returns to 0x3FFF when a commit completes.
// R6 - Unloaded latches stay blank so their words stay unprogrammed.
// R7 - With latch-load-only set, an unlock only loads the addressed latch.
// R8 - With latch-load-only clear, an unlock loads then commits the row; the code commits only with the region select clear, and with it set only loads.
// R9 - An interrupted unlock loads nothing and writes nothing.
// R10 - Software sets the enables, loads address and data, and unlocks.
// R11 - Software repeats address, fill and commit for each row.
// R12 - The region select picks flash or the ID, config and EEPROM map.
// R13 - Unlock is 55h then AAh to the unlock register, then start.
// R14 - The start bit holds the processor stalled until the operation ends.
// R15 - The error flag sets on protected start, reset or broken unlock.
// R16 - An unlock completed with write enable clear is ignored.
// R17 - Hardware clears the start bit when the operation finishes.
module frw_programmer #(
	parameter int LATCHES = 32
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	output logic                        irq,
	output logic                        cpu_stall,
	output frw_pkg::frw_flash_type      flash,
	input  wire logic                   flash_ready
);
	import frw_pkg::*;

	logic [13:0]   latch_q [LATCHES];
	logic [13:0]   latch_d [LATCHES];
	frw_key_type   key_q, key_d;
	logic          start_q, write_enable_bit_q, latch_load_only_q, region_q, write_error_flag_q;
	logic          busy_q;
	logic [15:0]   addr_q;
	logic [13:0]   data_q;
	logic [5:0]    cnt_q;
	logic [1:0]    stat_q, mask_q;
	logic [31:0]   prdata_q;
	logic          pready_q, pslverr_q, irq_q, stall_q, rst_seen_q;
	logic          held_q;
	logic [5:0]    wcnt_q;
	frw_flash_type flash_q;

	function automatic logic wr_allowed(input logic reg_sel,
		input logic [15:0] a);
		if (!reg_sel)
			wr_allowed = (a >= PFM_FIRST) && (a <= PFM_LAST);
		else
			wr_allowed = ((a >= PFM_FIRST) && (a <= UID_LAST)) ||
				((a >= EE_FIRST) && (a <= EE_LAST));
	endfunction

	wire acc      = psel && penable && !pready_q;
	// A stalled access is taken once; its waiting cycles do not repeat it.
	wire take     = acc && !held_q;
	wire wr_acc   = take && pwrite;
	wire rd_acc   = take && !pwrite;
	wire hit_ctrl = paddr == ADDR_CTRL;
	wire hit_unl  = paddr == ADDR_UNLOCK;
	wire hit_addr = paddr == ADDR_NVADDR;
	wire hit_data = paddr == ADDR_NVDATA;
	wire hit_stat = paddr == ADDR_IRQ_STAT;
	wire hit_mask = paddr == ADDR_IRQ_MASK;
	wire mapped   = hit_ctrl | hit_unl | hit_addr | hit_data |
		hit_stat | hit_mask;
	wire wr_ctrl  = wr_acc && hit_ctrl;
	wire wr_unl   = wr_acc && hit_unl;
	wire start_req = wr_ctrl && pwdata[CTRL_START] && !start_q && !busy_q;
	wire armed    = key_q == KEY_ARMED;
	wire [4:0] idx = addr_q[4:0];                 // [R3]
	wire [9:0] row = addr_q[14:5];                // [R3]
	wire prot     = !wr_allowed(region_q, addr_q);
	// Any register write other than the next key step or a start breaks the sequence.
	wire key_break = (key_q != KEY_IDLE) && wr_acc && !start_req &&
		!(wr_unl && key_q == KEY_GOT55 && pwdata[7:0] == KEY_SECOND);
	wire go       = start_req && armed && write_enable_bit_q; // [R13] [R16]
	wire do_load  = go && !prot;                  // [R7] [R8]
	wire do_commit = do_load && !latch_load_only_q && !region_q;
	wire err_set  = (start_req && armed && write_enable_bit_q && prot) ||
		(start_req && !armed) || key_break || rst_seen_q; // [R15] [R9]
	wire commit_end = busy_q && flash_ready &&
		cnt_q == 6'(LATCHES - 1);
	wire [1:0] ev = {err_set, commit_end || (do_load && !do_commit)};

	always_comb begin
		key_d = key_q;
		if (start_req || key_break)
			key_d = KEY_IDLE;
		else if (wr_unl && key_q == KEY_IDLE && pwdata[7:0] == KEY_FIRST)
			key_d = KEY_GOT55;
		else if (wr_unl && key_q == KEY_GOT55)
			key_d = KEY_ARMED;
	end

	genvar g;
	generate
		for (g = 0; g < LATCHES; g++) begin : g_latch
			assign latch_d[g] = commit_end ? LATCH_BLANK :          // [R5]
				(do_load && idx == 5'(g)) ? data_q : latch_q[g]; // [R6]
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n)
					latch_q[g] <= LATCH_BLANK;
				else
					latch_q[g] <= latch_d[g];
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			key_q      <= KEY_IDLE;
			write_enable_bit_q     <= 1'b0;
			latch_load_only_q     <= 1'b0;
			region_q   <= 1'b0;
			addr_q     <= 16'h0000;
			data_q     <= 14'h0000;
			mask_q     <= 2'h0;
			rst_seen_q <= 1'b1;
		end else begin
			key_q      <= key_d;
			rst_seen_q <= 1'b0;
			if (wr_ctrl) begin
				write_enable_bit_q   <= pwdata[CTRL_WRITE_ENABLE_BIT];
				latch_load_only_q   <= pwdata[CTRL_LATCH_LOAD_ONLY];
				region_q <= pwdata[CTRL_REGION];          // [R12]
			end
			if (wr_acc && hit_addr)
				addr_q <= pwdata[15:0];
			if (wr_acc && hit_data)
				data_q <= pwdata[13:0];
			if (wr_acc && hit_mask)
				mask_q <= pwdata[1:0];
		end
	end

	// Start is held by hardware for the whole commit and then cleared.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			start_q <= 1'b0;
			busy_q  <= 1'b0;
			cnt_q   <= 6'h00;
			write_error_flag_q <= 1'b0;
		end else begin
			if (do_commit) begin
				busy_q  <= 1'b1;
				start_q <= 1'b1;
				cnt_q   <= 6'h00;
			end else if (commit_end) begin
				busy_q  <= 1'b0;
				start_q <= 1'b0;                          // [R17]
			end else if (busy_q && flash_ready)
				cnt_q <= cnt_q + 6'h01;                   // [R2]
			if (err_set)
				write_error_flag_q <= 1'b1;                          // [R15]
			else if (wr_ctrl && !pwdata[CTRL_WRITE_ERROR_FLAG])
				write_error_flag_q <= 1'b0;
		end
	end

	// Flash port presents one latch per flash_ready cycle, with the row taken from addr_q each cycle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			flash_q <= '0;
		else begin
			flash_q.we     <= busy_q && flash_ready && !commit_end;
			flash_q.row    <= row;                        // [R4]
			flash_q.region <= region_q;
			flash_q.index  <= cnt_q[4:0];
			flash_q.data   <= latch_q[cnt_q[4:0]];
			if (commit_end) begin
				flash_q.we    <= 1'b1;
				flash_q.index <= 5'(LATCHES - 1);
				flash_q.data  <= latch_q[LATCHES - 1];
			end
		end
	end

	// Counts the words handed to the flash since the commit began.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			wcnt_q <= 6'h00;
		else if (do_commit)
			wcnt_q <= 6'h00;
		else if (flash_q.we)
			wcnt_q <= wcnt_q + 6'h01;
	end

	wire [31:0] ctrl_rd = 32'({busy_q, write_error_flag_q, region_q, latch_load_only_q,
		write_enable_bit_q, start_q});
	wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
		hit_addr ? {16'h0000, addr_q} :
		hit_data ? {18'h00000, data_q} :
		hit_stat ? {30'h0, stat_q} :
		hit_mask ? {30'h0, mask_q} : 32'h0000_0000;

	// Status bits are sticky; a read clears them but a new event wins.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stat_q    <= 2'h0;
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q     <= 1'b0;
			stall_q   <= 1'b0;
			held_q    <= 1'b0;
		end else begin
			stat_q    <= ((rd_acc && hit_stat) ? 2'h0 : stat_q) | ev;
			pready_q  <= acc && !(busy_q || do_commit);  // [R14]
			held_q    <= acc && (busy_q || do_commit);   // [R14]
			pslverr_q <= acc && !mapped && !(busy_q || do_commit);
			prdata_q  <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
			irq_q     <= |(stat_q & mask_q);
			stall_q   <= busy_q || do_commit;             // [R14]
		end
	end

	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign irq       = irq_q;
	assign cpu_stall = stall_q;
	assign flash     = flash_q;

	a_load_no_write: assert property ( // [R7]
		@(posedge clk_sys) disable iff (!rst_n)
		go && latch_load_only_q && !prot |=> !busy_q)
		else $error("Latch-only unlock started a flash write.");
	a_commit_starts: assert property ( // [R8]
		@(posedge clk_sys) disable iff (!rst_n)
		do_commit |=> busy_q && start_q)
		else $error("Commit did not start after unlock.");
	a_commit_length: assert property ( // [R2]
		@(posedge clk_sys) disable iff (!rst_n)
		$fell(busy_q) |-> flash_q.we && wcnt_q == 6'(LATCHES - 1))
		else $error("Commit did not span 32 latches.");
	a_blank_after: assert property ( // [R5]
		@(posedge clk_sys) disable iff (!rst_n)
		commit_end |=> latch_q[0] == LATCH_BLANK)
		else $error("Latches not blanked after commit.");
	a_row_stable: assert property ( // [R4]
		@(posedge clk_sys) disable iff (!rst_n)
		flash_q.we |=> !flash_q.we || $stable(flash_q.row))
		else $error("Commit row changed mid operation.");
	a_broken_unlock: assert property ( // [R9]
		@(posedge clk_sys) disable iff (!rst_n)
		start_req && !armed |-> !do_load ##1 write_error_flag_q)
		else $error("Broken unlock was not refused.");
	a_write_enable_bit_gate: assert property ( // [R16]
		@(posedge clk_sys) disable iff (!rst_n)
		!write_enable_bit_q |-> !do_load)
		else $error("Load happened with writes disabled.");
	a_start_clear: assert property ( // [R17]
		@(posedge clk_sys) disable iff (!rst_n)
		commit_end |=> !start_q)
		else $error("Start bit not cleared after commit.");
	a_stall_hold: assert property ( // [R14]
		@(posedge clk_sys) disable iff (!rst_n)
		busy_q |=> cpu_stall)
		else $error("Processor not stalled during commit.");
	a_err_protect: assert property ( // [R15] [R12]
		@(posedge clk_sys) disable iff (!rst_n)
		go && prot |=> write_error_flag_q && !busy_q)
		else $error("Protected address start did not flag error.");

	a_pready_pulse: assert property ( // [R14]
		@(posedge clk_sys) disable iff (!rst_n)
		pready |=> !pready)
		else $error("Ready stood longer than one cycle.");
	a_ready_excl: assert property ( // [R14]
		@(posedge clk_sys) disable iff (!rst_n)
		cpu_stall |-> !pready)
		else $error("Access ended while the processor was stalled.");
	a_slverr_pair: assert property ( // [R12]
		@(posedge clk_sys) disable iff (!rst_n)
		pslverr |-> pready)
		else $error("Slave error seen without ready.");
	a_idle_no_write: assert property ( // [R7]
		@(posedge clk_sys) disable iff (!rst_n)
		!$past(busy_q) |-> !flash_q.we)
		else $error("Flash written outside a commit.");
	a_commit_gate: assert property ( // [R8]
		@(posedge clk_sys) disable iff (!rst_n)
		do_commit |-> write_enable_bit_q && !latch_load_only_q && !region_q && !prot)
		else $error("Commit started without its conditions.");
	a_blank_last: assert property ( // [R5]
		@(posedge clk_sys) disable iff (!rst_n)
		commit_end |=> latch_q[LATCHES - 1] == LATCH_BLANK)
		else $error("Last latch not blanked after commit.");
	a_err_sticky: assert property ( // [R15]
		@(posedge clk_sys) disable iff (!rst_n)
		write_error_flag_q && !wr_ctrl |=> write_error_flag_q)
		else $error("Error flag dropped without a clear.");
	a_break_err: assert property ( // [R9]
		@(posedge clk_sys) disable iff (!rst_n)
		key_break |=> write_error_flag_q && key_q == KEY_IDLE)
		else $error("Broken unlock left the sequence armed.");
	a_done_event: assert property ( // [R17]
		@(posedge clk_sys) disable iff (!rst_n)
		commit_end |=> stat_q[IRQ_DONE])
		else $error("Commit end did not set done status.");
	a_stat_sticky: assert property ( // [R17]
		@(posedge clk_sys) disable iff (!rst_n)
		stat_q[IRQ_DONE] && !(rd_acc && hit_stat) |=> stat_q[IRQ_DONE])
		else $error("Done status dropped without a read.");
	a_start_held: assert property ( // [R17]
		@(posedge clk_sys) disable iff (!rst_n)
		busy_q |-> start_q)
		else $error("Start bit low during a commit.");
	a_irq_level: assert property ( // [R17]
		@(posedge clk_sys) disable iff (!rst_n)
		irq == |($past(stat_q) & $past(mask_q)))
		else $error("Interrupt does not follow masked status.");
	a_load_target: assert property ( // [R7] [R3]
		@(posedge clk_sys) disable iff (!rst_n)
		do_load |=> latch_q[idx] == $past(data_q))
		else $error("Addressed latch did not take the data.");
	a_region_no_commit: assert property ( // [R12]
		@(posedge clk_sys) disable iff (!rst_n)
		do_load && region_q |=> !busy_q)
		else $error("Region one load started a commit.");

	c_latch_load: cover property (@(posedge clk_sys) disable iff (!rst_n)
		do_load && !do_commit);
	c_row_commit: cover property (@(posedge clk_sys) disable iff (!rst_n)
		commit_end);
	c_unlock_break: cover property (@(posedge clk_sys) disable iff (!rst_n)
		key_break);
	c_protect_err: cover property (@(posedge clk_sys) disable iff (!rst_n)
		go && prot);
	c_region_load: cover property (@(posedge clk_sys) disable iff (!rst_n)
		do_load && region_q);
endmodule

// ### tb/frw_programmer_tb.sv
/*
 * Testbench for frw_programmer: APB-driven scenarios and a flash-port monitor.
 * Assumes the frw_pkg package and one 250 MHz clock with a stalling flash.
 */
`timescale 1ns/1ps
module frw_programmer_tb;
	import frw_pkg::*;
	logic          clk_sys, rst_n, psel, penable, pwrite, flash_ready;
	logic          pready, pslverr, irq, cpu_stall, erf;
	logic [7:0]    paddr;
	logic [31:0]   pwdata, prdata, rd;
	frw_flash_type flash;
	int            err_total, check_count, we_cnt, stall_cnt, row_bad;
	logic [9:0]    exp_row;
	logic [13:0]   seen [32];

	frw_programmer #(.LATCHES(ROW_WORDS)) i_dut (.clk_sys(clk_sys),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .cpu_stall(cpu_stall), .flash(flash),
		.flash_ready(flash_ready));

	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end

	// The flash stalls every other cycle; words written are recorded.
	always @(posedge clk_sys) begin
		flash_ready <= ~flash_ready;
		if (cpu_stall === 1'b1) stall_cnt++;
		if (flash.we === 1'b1) begin
			we_cnt++;
			seen[flash.index] = flash.data;
			if (flash.row !== exp_row) row_bad++;
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 3000);
		chk("pready", 32'h1, 32'(pready));
		rd = prdata;
		erf = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic unlock(input logic [31:0] ctl);
		apb(1, ADDR_UNLOCK, {24'h0, KEY_FIRST});
		apb(1, ADDR_UNLOCK, {24'h0, KEY_SECOND});
		apb(1, ADDR_CTRL, ctl);
	endtask

	task automatic put(input logic [15:0] a, input logic [13:0] d,
		input logic [31:0] ctl);
		apb(1, ADDR_NVADDR, {16'h0, a});
		apb(1, ADDR_NVDATA, {18'h0, d});
		apb(1, ADDR_CTRL, ctl & 32'hFFFFFFFE);
		unlock(ctl);
	endtask

	task automatic t_reset;
		apb(0, ADDR_CTRL, 32'h0);
		chk("ctrl reset", 32'h10, rd);
		apb(0, ADDR_IRQ_STAT, 32'h0);
		chk("status reset", 32'h2, rd);
		apb(0, ADDR_IRQ_STAT, 32'h0);
		chk("status cleared", 32'h0, rd);
		apb(1, 8'h18, 32'hFFFF);
		chk("slverr write", 32'h1, 32'(erf));
		apb(0, 8'h18, 32'h0);
		chk("slverr read", 32'h1, 32'(erf));
		$display("test reset done");
	endtask

	task automatic t_commit;
		we_cnt = 0;
		stall_cnt = 0;
		row_bad = 0;
		exp_row = 10'd9;
		put(16'h8123, 14'h1234, 32'h7);
		chk("load writes", 32'h0, 32'(we_cnt));
		put(16'h8127, 14'h0ABC, 32'h3);
		chk("words", 32'(ROW_WORDS), 32'(we_cnt));
		chk("latch 3", 32'h1234, 32'(seen[3]));
		chk("latch 7", 32'h0ABC, 32'(seen[7]));
		chk("latch 0", 32'(LATCH_BLANK), 32'(seen[0]));
		chk("latch 31", 32'(LATCH_BLANK), 32'(seen[31]));
		chk("row", 32'h0, 32'(row_bad));
		chk("stall", 32'h1, 32'(stall_cnt > 0));
		apb(0, ADDR_CTRL, 32'h0);
		chk("start clear", 32'h0, rd & 32'h21);
		put(16'h8120, 14'h0001, 32'h3);
		chk("relatch 3", 32'(LATCH_BLANK), 32'(seen[3]));
		chk("relatch 0", 32'h1, 32'(seen[0]));
		$display("test commit done");
	endtask

	task automatic t_guard;
		we_cnt = 0;
		apb(1, ADDR_CTRL, 32'h2);
		apb(1, ADDR_UNLOCK, {24'h0, KEY_FIRST});
		apb(1, ADDR_NVDATA, 32'h5);
		apb(1, ADDR_UNLOCK, {24'h0, KEY_SECOND});
		apb(1, ADDR_CTRL, 32'h3);
		chk("broken writes", 32'h0, 32'(we_cnt));
		apb(0, ADDR_CTRL, 32'h0);
		chk("broken err", 32'h10, rd & 32'h10);
		put(16'h8120, 14'h0055, 32'h1);
		chk("no write_enable_bit", 32'h0, 32'(we_cnt));
		put(16'h8000, 14'h0011, 32'hB);
		apb(0, ADDR_CTRL, 32'h0);
		chk("user id ok", 32'h0, rd & 32'h10);
		put(16'h8005, 14'h0011, 32'hB);
		apb(0, ADDR_CTRL, 32'h0);
		chk("protected", 32'h10, rd & 32'h10);
		chk("region1 writes", 32'h0, 32'(we_cnt));
		$display("test guard done");
	endtask

	task automatic t_irq;
		apb(1, ADDR_IRQ_MASK, 32'h1);
		apb(0, ADDR_IRQ_STAT, 32'h0);
		put(16'h8120, 14'h0002, 32'h7);
		repeat (2) @(posedge clk_sys);
		chk("irq set", 32'h1, 32'(irq));
		apb(0, ADDR_IRQ_STAT, 32'h0);
		chk("done stat", 32'h1, rd & 32'h1);
		repeat (3) @(posedge clk_sys);
		chk("irq clear", 32'h0, 32'(irq));
		$display("test irq done");
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		results;
	end

	initial begin
		rst_n = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 8'h00;
		pwdata = 32'h0;
		flash_ready = 0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1;
		t_reset;
		t_commit;
		t_guard;
		t_irq;
		results;
	end
endmodule
